// ===== src/updown_cfg.svh
`ifndef UPDOWN_CFG_SVH
`define UPDOWN_CFG_SVH
// register offsets (8-bit address)
`define REG_FREQ_SRC     8'h00
`define REG_UD_MODE      8'h01
`define REG_UD_STEP      8'h02
`define REG_DWELL_FREQ   8'h03
`define REG_DWELL_TIME   8'h04
`define REG_IN_FUNC0     8'h05
`define REG_MAX_FREQ     8'h0a
`define REG_UPPER        8'h0b
`define REG_LOWER        8'h0c
`define REG_CMD_FREQ     8'h0d
`define REG_SAVED_FREQ   8'h0e
`define REG_STATUS       8'h0f
`define REG_ACC_RATE     8'h10
`define REG_DEC_RATE     8'h11
// codes
`define FREQ_SRC_UPDOWN  4'ha
`define FUNC_UP          5'h0f
`define FUNC_DOWN        5'h10
`define FUNC_3WIRE       5'h11
`define FUNC_MAX         5'h1b
`define MODE_MAX         2'h2
// reset values and the dwell time limit, 0.01 Hz units, time in 0.1 s
`define RST_DWELL_FREQ   16'h01f4
`define RST_MAX_FREQ     16'h1770
`define RST_INFUNC_BASE  5'h00
`define RST_ACC_RATE     16'h0001
`define RST_DWELL_TMAX   8'h64
// timing
`define CLK_HZ           40000000
`define HOLD_COMPOUND_MS 3000
`define TENTH_SEC_MS     100
`endif

// ===== src/updown_pkg.sv
package updown_pkg;
	typedef enum logic [1:0] {
		MODE_CONT,
		MODE_STEP,
		MODE_COMPOUND
	} ud_mode_t;
	typedef enum {
		ST_IDLE,
		ST_DWELL,
		ST_RUN
	} run_state_t;
endpackage : updown_pkg

// ===== src/input_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for one external level
module input_sync (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// pin and synced level
	input  wire logic pin,
	output logic      level
);
	logic meta_r;
	logic meta_nxt;
	logic level_r;
	logic level_nxt;

	// second flop is the only reader of the first
	always_comb begin
		meta_nxt  = pin;
		level_nxt = meta_r;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_r  <= 1'b0;
			level_r <= 1'b0;
		end else begin
			meta_r  <= meta_nxt;
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
endmodule : input_sync

// ===== src/updown_freq_command_dwell.sv
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "updown_cfg.svh"
// What this block does
// [RULE1] up/down only acts when the reference source selector equals ten
// [RULE2] each input terminal has a function code limited to 0 through 27
// [RULE3] code 15 makes a terminal the up input, code 16 the down input
// [RULE4] mode selector 0 continuous, 1 edge step, 2 compound; resets to 0
// [RULE5] step frequency resets to zero and is limited to maximum frequency
// [RULE6] mode 0 up ramps toward maximum at accel rate, clamped by upper limit
// [RULE7] mode 0 down ramps down at decel rate, clamped by lower limit
// [RULE8] mode 1 rising edge of up or down moves target by one step
// [RULE9] falling edge of up or down saves the command frequency
// [RULE10] stop while up or down active blocks saving until both release
// [RULE11] mode 2 steps on edges, becomes continuous after 3 s hold
// [RULE12] edges arriving before the previous step completes are ignored
// [RULE13] code 17 makes a terminal the 3-wire command input
// [RULE14] 3-wire run latches a momentary run until stop
// [RULE15] external 3-wire pulses last at least 50 ms
// [RULE16] run first outputs dwell frequency for dwell time, then accelerates
// [RULE17] dwell frequency resets to 5.00 Hz, dwell time 0.0 to 10.0 s
// [RULE18] dwell skipped when dwell time or dwell frequency is zero
// [RULE19] dwell only on the first acceleration after a run command
// [RULE20] dwell overrides jog, jog overrides up/down, multi-step and 3-wire
// [RULE21] command frequency stays within lower and upper bounds; only up/down targets are clamped, not base_freq, jog or dwell
module updown_freq_command_dwell #(
	parameter int NUM_INPUTS   = 5,
	parameter int HOLD_CYCLES  = `CLK_HZ / 1000 * `HOLD_COMPOUND_MS,
	parameter int TENTH_CYCLES = `CLK_HZ / 1000 * `TENTH_SEC_MS
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// register port
	input  wire logic [7:0]            reg_addr,
	input  wire logic [15:0]           reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [15:0]           reg_rdata,
	// terminals and commands
	input  wire logic [NUM_INPUTS-1:0] input_terminal,
	input  wire logic                  run_cmd,
	input  wire logic                  stop_cmd,
	input  wire logic                  jog_active,
	input  wire logic [15:0]           jog_freq,
	input  wire logic [15:0]           base_freq,
	// outputs to the frequency ramp
	output logic      [15:0]           cmd_freq,
	output logic                       running,
	output logic                       dwelling
);
	import updown_pkg::*;

	localparam int DCW = $clog2(TENTH_CYCLES + 1);
	localparam int HCW = $clog2(HOLD_CYCLES + 1);

	logic [NUM_INPUTS-1:0] term_s;
	logic [3:0]  freq_src_r, freq_src_nxt;
	ud_mode_t    mode_r, mode_nxt;
	logic [15:0] step_r, step_nxt, dfreq_r, dfreq_nxt, maxf_r, maxf_nxt;
	logic [15:0] upper_r, upper_nxt, lower_r, lower_nxt, acc_r, acc_nxt, dec_r, dec_nxt;
	logic [7:0]  dtime_r, dtime_nxt;
	logic [4:0]  func_r [NUM_INPUTS];
	logic [4:0]  func_nxt [NUM_INPUTS];
	logic [15:0] rdata_r, rdata_nxt;
	logic [15:0] freq_r, freq_nxt, target_r, target_nxt, saved_r, saved_nxt;
	logic        up_d_r, dn_d_r, save_blk_r, save_blk_nxt, wire3_r, wire3_nxt;
	logic [HCW-1:0] hold_r, hold_nxt;
	run_state_t  st_r, st_nxt;
	logic        dwell_done_r, dwell_done_nxt;
	logic [DCW-1:0] tick_r, tick_nxt;
	logic [7:0]  dcnt_r, dcnt_nxt;
	logic        up_lv, dn_lv, w3_lv, ud_en, hi_lim;
	logic [15:0] top_f, bot_f;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_sync
			input_sync u_sync (
				.clock (clock),
				.rst   (rst),
				.pin   (input_terminal[gi]),
				.level (term_s[gi])
			);
		end
	endgenerate

	// terminal role decode
	always_comb begin
		up_lv = 1'b0;
		dn_lv = 1'b0;
		w3_lv = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			// [RULE3] up and down
			if (func_r[i] == `FUNC_UP)
				up_lv = up_lv | term_s[i];
			if (func_r[i] == `FUNC_DOWN)
				dn_lv = dn_lv | term_s[i];
			// [RULE13] 3-wire input
			if (func_r[i] == `FUNC_3WIRE)
				w3_lv = w3_lv | term_s[i];
		end
		// [RULE1] source gate
		ud_en  = (freq_src_r == `FREQ_SRC_UPDOWN);
		// [RULE21] bounds, upper limit only when set
		top_f  = (upper_r != 16'h0000 && upper_r < maxf_r) ? upper_r : maxf_r;
		bot_f  = (lower_r < top_f) ? lower_r : top_f;
		hi_lim = (hold_r == HCW'(HOLD_CYCLES));
	end

	// register writes and read data
	always_comb begin
		freq_src_nxt = freq_src_r;
		mode_nxt     = mode_r;
		step_nxt     = step_r;
		dfreq_nxt    = dfreq_r;
		dtime_nxt    = dtime_r;
		maxf_nxt     = maxf_r;
		upper_nxt    = upper_r;
		lower_nxt    = lower_r;
		acc_nxt      = acc_r;
		dec_nxt      = dec_r;
		func_nxt     = func_r;
		rdata_nxt    = 16'h0000;
		if (reg_write) begin
			case (reg_addr)
				`REG_FREQ_SRC:   freq_src_nxt = reg_wdata[3:0];
				// [RULE4] illegal codes ignored
				`REG_UD_MODE:    if (reg_wdata[1:0] <= `MODE_MAX) mode_nxt = ud_mode_t'(reg_wdata[1:0]);
				// [RULE5] step limited to maximum
				`REG_UD_STEP:    step_nxt = (reg_wdata > maxf_r) ? maxf_r : reg_wdata;
				// [RULE17] dwell settings
				`REG_DWELL_FREQ: dfreq_nxt = (reg_wdata > maxf_r) ? maxf_r : reg_wdata;
				`REG_DWELL_TIME: if (reg_wdata[7:0] <= `RST_DWELL_TMAX) dtime_nxt = reg_wdata[7:0];
				`REG_MAX_FREQ:   maxf_nxt = reg_wdata;
				`REG_UPPER:      upper_nxt = reg_wdata;
				`REG_LOWER:      lower_nxt = reg_wdata;
				`REG_ACC_RATE:   acc_nxt = reg_wdata;
				`REG_DEC_RATE:   dec_nxt = reg_wdata;
				default: begin
					for (int i = 0; i < NUM_INPUTS; i++)
						// [RULE2] codes 0 to 27
						if (reg_addr == `REG_IN_FUNC0 + 8'(i) && reg_wdata[4:0] <= `FUNC_MAX)
							func_nxt[i] = reg_wdata[4:0];
				end
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				`REG_FREQ_SRC:   rdata_nxt = {12'h000, freq_src_r};
				`REG_UD_MODE:    rdata_nxt = {14'h0000, mode_r};
				`REG_UD_STEP:    rdata_nxt = step_r;
				`REG_DWELL_FREQ: rdata_nxt = dfreq_r;
				`REG_DWELL_TIME: rdata_nxt = {8'h00, dtime_r};
				`REG_MAX_FREQ:   rdata_nxt = maxf_r;
				`REG_UPPER:      rdata_nxt = upper_r;
				`REG_LOWER:      rdata_nxt = lower_r;
				`REG_CMD_FREQ:   rdata_nxt = freq_r;
				`REG_SAVED_FREQ: rdata_nxt = saved_r;
				`REG_STATUS:     rdata_nxt = {11'h000, wire3_r, save_blk_r, dwell_done_r,
					st_r == ST_DWELL, st_r != ST_IDLE};
				`REG_ACC_RATE:   rdata_nxt = acc_r;
				`REG_DEC_RATE:   rdata_nxt = dec_r;
				default: begin
					for (int i = 0; i < NUM_INPUTS; i++)
						if (reg_addr == `REG_IN_FUNC0 + 8'(i))
							rdata_nxt = {11'h000, func_r[i]};
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			freq_src_r <= 4'h0;
			mode_r     <= MODE_CONT;
			step_r     <= 16'h0000;
			dfreq_r    <= `RST_DWELL_FREQ;
			dtime_r    <= 8'h00;
			maxf_r     <= `RST_MAX_FREQ;
			upper_r    <= 16'h0000;
			lower_r    <= 16'h0000;
			acc_r      <= `RST_ACC_RATE;
			dec_r      <= `RST_ACC_RATE;
			for (int i = 0; i < NUM_INPUTS; i++)
				func_r[i] <= `RST_INFUNC_BASE;
			rdata_r    <= 16'h0000;
		end else begin
			freq_src_r <= freq_src_nxt;
			mode_r     <= mode_nxt;
			step_r     <= step_nxt;
			dfreq_r    <= dfreq_nxt;
			dtime_r    <= dtime_nxt;
			maxf_r     <= maxf_nxt;
			upper_r    <= upper_nxt;
			lower_r    <= lower_nxt;
			acc_r      <= acc_nxt;
			dec_r      <= dec_nxt;
			func_r     <= func_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// run state, 3-wire latch and dwell timing
	always_comb begin
		st_nxt         = st_r;
		wire3_nxt      = wire3_r;
		dwell_done_nxt = dwell_done_r;
		tick_nxt       = tick_r;
		dcnt_nxt       = dcnt_r;
		// [RULE14] latch momentary run
		if (stop_cmd)
			wire3_nxt = 1'b0;
		else if (w3_lv && run_cmd)
			wire3_nxt = 1'b1;
		case (st_r)
			ST_IDLE: begin
				tick_nxt = '0;
				dcnt_nxt = 8'h00;
				if ((run_cmd || wire3_r) && !stop_cmd) begin
					// [RULE18] zero time or freq skips dwell
					// [RULE19] only the first acceleration dwells
					if (dtime_r == 8'h00 || dfreq_r == 16'h0000 || dwell_done_r)
						st_nxt = ST_RUN;
					else
						st_nxt = ST_DWELL;
				end
			end
			ST_DWELL: begin
				// [RULE16] hold dwell then go on
				if (stop_cmd) begin
					st_nxt = ST_IDLE;
				end else if (tick_r == DCW'(TENTH_CYCLES - 1)) begin
					tick_nxt = '0;
					dcnt_nxt = dcnt_r + 8'h01;
					if (dcnt_r + 8'h01 >= dtime_r) begin
						st_nxt         = ST_RUN;
						dwell_done_nxt = 1'b1;
					end
				end else begin
					tick_nxt = tick_r + DCW'(1);
				end
			end
			ST_RUN: begin
				if (stop_cmd)
					st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
		// a stop command while idle, with no run or 3-wire latch pending, rearms dwell
		if (st_r == ST_IDLE && !run_cmd && !wire3_r && stop_cmd)
			dwell_done_nxt = 1'b0;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_r         <= ST_IDLE;
			wire3_r      <= 1'b0;
			dwell_done_r <= 1'b0;
			tick_r       <= '0;
			dcnt_r       <= 8'h00;
		end else begin
			st_r         <= st_nxt;
			wire3_r      <= wire3_nxt;
			dwell_done_r <= dwell_done_nxt;
			tick_r       <= tick_nxt;
			dcnt_r       <= dcnt_nxt;
		end
	end

	// up/down target, ramp and save
	always_comb begin
		target_nxt   = target_r;
		freq_nxt     = freq_r;
		saved_nxt    = saved_r;
		save_blk_nxt = save_blk_r;
		hold_nxt     = (up_lv || dn_lv) ? (hi_lim ? hold_r : hold_r + HCW'(1)) : '0;
		if (ud_en && st_r == ST_RUN && !jog_active) begin
			// [RULE6] continuous up, [RULE11] after long hold
			if (up_lv && (mode_r == MODE_CONT || (mode_r == MODE_COMPOUND && hi_lim)))
				target_nxt = top_f;
			// [RULE7] continuous down
			else if (dn_lv && (mode_r == MODE_CONT || (mode_r == MODE_COMPOUND && hi_lim)))
				target_nxt = bot_f;
			else if (!up_lv && !dn_lv
					&& (mode_r == MODE_CONT || (mode_r == MODE_COMPOUND && hi_lim)))
				target_nxt = freq_r;
			// [RULE12] edge ignored while step pending
			else if (mode_r != MODE_CONT && freq_r == target_r) begin
				// [RULE8] step per rising edge
				if (up_lv && !up_d_r)
					target_nxt = (top_f - freq_r > step_r) ? freq_r + step_r : top_f;
				else if (dn_lv && !dn_d_r)
					target_nxt = (freq_r - bot_f > step_r) ? freq_r - step_r : bot_f;
			end
		end else if (!ud_en) begin
			target_nxt = base_freq;
		end
		// [RULE10] stop while held blocks the save
		if (stop_cmd && (up_lv || dn_lv))
			save_blk_nxt = 1'b1;
		else if (!stop_cmd && !up_lv && !dn_lv)
			save_blk_nxt = 1'b0;
		// [RULE9] save on falling edge
		if (ud_en && !save_blk_r && !stop_cmd && ((up_d_r && !up_lv) || (dn_d_r && !dn_lv)))
			saved_nxt = freq_r;
		// ramp toward target
		case (st_r)
			ST_IDLE: freq_nxt = 16'h0000;
			// [RULE20] dwell first, then jog
			ST_DWELL: freq_nxt = dfreq_r;
			ST_RUN: begin
				if (jog_active)
					freq_nxt = jog_freq;
				else if (freq_r < target_r)
					freq_nxt = (target_r - freq_r > acc_r) ? freq_r + acc_r : target_r;
				else if (freq_r > target_r)
					freq_nxt = (freq_r - target_r > dec_r) ? freq_r - dec_r : target_r;
			end
			default: freq_nxt = 16'h0000;
		endcase
		if (st_r == ST_IDLE)
			target_nxt = ud_en ? saved_r : base_freq;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			target_r   <= 16'h0000;
			freq_r     <= 16'h0000;
			saved_r    <= 16'h0000;
			save_blk_r <= 1'b0;
			hold_r     <= '0;
			up_d_r     <= 1'b0;
			dn_d_r     <= 1'b0;
		end else begin
			target_r   <= target_nxt;
			freq_r     <= freq_nxt;
			saved_r    <= saved_nxt;
			save_blk_r <= save_blk_nxt;
			hold_r     <= hold_nxt;
			up_d_r     <= up_lv;
			dn_d_r     <= dn_lv;
		end
	end

	assign reg_rdata = rdata_r;
	assign cmd_freq  = freq_r;
	assign running   = (st_r != ST_IDLE);
	assign dwelling  = (st_r == ST_DWELL);
endmodule : updown_freq_command_dwell

// ===== verification/updown_checker.sv
`timescale 1ns/1ps
`include "updown_cfg.svh"
// port-level watch on the sequencer; dwell limit follows the tenth-second count
module updown_checker #(
	parameter int TENTH_CYCLES = 4
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_read,
	input wire logic [15:0] reg_rdata,
	// commands and outputs
	input wire logic        run_cmd,
	input wire logic        stop_cmd,
	input wire logic        jog_active,
	input wire logic [15:0] cmd_freq,
	input wire logic        running,
	input wire logic        dwelling
);
	logic [15:0] dwell_cnt_r;
	logic [15:0] dwell_cnt_nxt;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// dwell length counter, so a dwell that never ends is caught
	always_comb begin
		dwell_cnt_nxt = dwelling ? dwell_cnt_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dwell_cnt_r <= 16'h0000;
		end else begin
			dwell_cnt_r <= dwell_cnt_nxt;
		end
	end
	a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside its slot");
	a_mode_legal: assert property (reg_read && reg_addr == `REG_UD_MODE |=> reg_rdata <= 16'h0002)
		else $error("mode register holds an illegal value");
	a_func_legal: assert property (reg_read && reg_addr inside {[8'h05:8'h09]}
		|=> reg_rdata <= 16'h001b)
		else $error("terminal function code out of range");
	// a dwell never runs at zero hertz, so from its second cycle on the output is nonzero
	a_dwell_in_run: assert property (dwelling && $past(dwelling)
		|-> running && cmd_freq != 16'h0000)
		else $error("dwell without run or at zero frequency");
	// the registered output reaches the dwell value one cycle after entry
	a_dwell_steady: assert property ($past(dwelling, 2) && $past(dwelling) && dwelling
		|-> $stable(cmd_freq))
		else $error("frequency moved during dwell");
	a_dwell_bound: assert property (dwell_cnt_r <= 16'(100 * TENTH_CYCLES + 2))
		else $error("dwell longer than the longest dwell time");
	// one unit per cycle at the default ramp rates, outside dwell entry, exit and jog
	a_ramp_rate: assert property (running && !dwelling && $past(running)
		&& !$past(dwelling) && !$past(jog_active) && !$past(jog_active, 2)
		|-> 16'(cmd_freq - $past(cmd_freq) + 16'h0001) <= 16'h0002)
		else $error("command frequency jumped");
	a_run_start: assert property (run_cmd && !stop_cmd |=> running)
		else $error("run not taken");
	a_upper_cap: assert property (cmd_freq <= `RST_MAX_FREQ)
		else $error("command above maximum frequency");
endmodule : updown_checker

bind updown_freq_command_dwell updown_checker #(.TENTH_CYCLES(TENTH_CYCLES)) chk_i (
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .run_cmd(run_cmd), .stop_cmd(stop_cmd), .jog_active(jog_active),
	.cmd_freq(cmd_freq), .running(running), .dwelling(dwelling)
);

// ===== verification/updown_buttons.sv
`timescale 1ns/1ps
// push buttons on the terminals; W3_MIN is a scaled stand-in for the minimum press
module updown_buttons #(
	parameter int W3_MIN = 8
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// requested presses: up, down, 3-wire
	input  wire logic [2:0] press,
	// terminal pins
	output logic      [4:0] pins
);
	int hold;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			hold <= 0;
		end else if (press[2]) begin
			hold <= W3_MIN;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
	end
	// terminal roles: 1 is 3-wire, 4 up, 5 down; open contacts read low
	assign pins = {press[1], press[0], 2'b00, press[2] || hold > 0};
endmodule : updown_buttons

// ===== verification/tb_updown_freq_command_dwell.sv
`timescale 1ns/1ps
`include "updown_cfg.svh"
// bench with shortened hold and tenth-second counts; jog is raised in two short scenarios
module tb_updown_freq_command_dwell;
	logic        clock;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [15:0] reg_rdata;
	logic [4:0]  input_terminal;
	logic        run_cmd;
	logic        stop_cmd;
	logic [15:0] base_freq;
	logic        jog_active;
	logic [15:0] jog_freq;
	logic [15:0] cmd_freq;
	logic        running;
	logic        dwelling;
	logic [2:0]  btn;
	logic [15:0] rv;
	int          fails;
	int          num_checks;
	int          cycles;
	int          m_freq;
	int          step;
	int          n;
	logic [7:0]  ra [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h05, 8'h09, 8'h20};
	logic [15:0] rs [8] = '{16'h0, 16'h0, `RST_DWELL_FREQ, 16'h0, `RST_MAX_FREQ, 16'h0, 16'h0, 16'h0};
	updown_freq_command_dwell #(.NUM_INPUTS(5), .HOLD_CYCLES(50), .TENTH_CYCLES(4)) uut (
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.input_terminal(input_terminal), .run_cmd(run_cmd), .stop_cmd(stop_cmd),
		.jog_active(jog_active), .jog_freq(jog_freq), .base_freq(base_freq),
		.cmd_freq(cmd_freq), .running(running), .dwelling(dwelling)
	);
	updown_buttons #(.W3_MIN(8)) btn_i (.clock(clock), .rst(rst), .press(btn), .pins(input_terminal));
	// clock and hang guard
	always #12.5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rv = reg_rdata;
		chk(rv, e);
	endtask : rdchk
	// bounded wait for the ramp to settle on a value
	task automatic wait_f(input logic [15:0] e);
		n = 0;
		while (cmd_freq !== e && n < 1500) begin
			@(posedge clock);
			#1 n++;
		end
		chk(cmd_freq, e);
	endtask : wait_f
	task automatic push(input int b, input int c);
		@(posedge clock);
		btn[b] <= 1'b1;
		repeat (c) @(posedge clock);
		btn[b] <= 1'b0;
	endtask : push
	initial begin
		void'($urandom(60770));
		{clock, reg_addr, reg_wdata, reg_write, reg_read, run_cmd, stop_cmd} = '0;
		{btn, base_freq, fails, num_checks, cycles, jog_active, jog_freq} = '0;
		rst = 1'b1;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rdchk(ra[i], rs[i]);
		end
		// illegal writes leave the registers alone
		wr(`REG_UD_MODE, 16'h0003);
		rdchk(`REG_UD_MODE, 16'h0000);
		wr(`REG_IN_FUNC0, 16'h001c);
		rdchk(`REG_IN_FUNC0, 16'h0000);
		wr(`REG_DWELL_TIME, 16'h0065);
		rdchk(`REG_DWELL_TIME, 16'h0000);
		wr(`REG_FREQ_SRC, 16'h000a);
		wr(8'h08, 16'h000f);
		wr(8'h09, 16'h0010);
		wr(`REG_DWELL_FREQ, 16'h0100);
		wr(`REG_DWELL_TIME, 16'h0002);
		wr(`REG_UPPER, 16'h0200);
		wr(`REG_UD_MODE, 16'h0001);
		step = 32 + $urandom % 64;
		wr(`REG_UD_STEP, 16'(step));
		// run: dwell first, then ramp to the saved value
		// jog raised together with run must not displace the dwell
		@(posedge clock);
		run_cmd <= 1'b1;
		jog_freq <= 16'h0180;
		jog_active <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk(cmd_freq, 16'h0100);
		@(posedge clock);
		jog_active <= 1'b0;
		m_freq = 0;
		wait_f(16'(m_freq));
		// edge steps; the second of two quick edges must be dropped
		push(0, 3);
		m_freq += step;
		wait_f(16'(m_freq));
		push(0, 3);
		push(0, 3);
		m_freq += step;
		repeat (200) @(posedge clock);
		#1 chk(cmd_freq, 16'(m_freq));
		push(1, 3);
		m_freq -= step;
		wait_f(16'(m_freq));
		// compound: a long hold becomes a ramp up to the upper limit
		wr(`REG_UD_MODE, 16'h0002);
		// releasing a long hold mid-ramp stops the ramp where it stands
		push(0, 100);
		repeat (5) @(posedge clock);
		#1 rv = cmd_freq;
		repeat (20) @(posedge clock);
		#1 chk(cmd_freq, rv);
		push(0, 750);
		#1 chk(cmd_freq, 16'h0200);
		wr(`REG_UD_MODE, 16'h0000);
		wr(`REG_LOWER, 16'h0100);
		push(1, 400);
		#1 chk(cmd_freq, 16'h0100);
		push(0, 400);
		#1 chk(cmd_freq, 16'h0200);
		repeat (6) @(posedge clock);
		rdchk(`REG_SAVED_FREQ, 16'h0200);
		// stop while down is held: the saved value must not follow, even when
		// the stop is withdrawn before the button lets go
		@(posedge clock);
		btn[1] <= 1'b1;
		repeat (40) @(posedge clock);
		stop_cmd <= 1'b1;
		run_cmd <= 1'b0;
		repeat (5) @(posedge clock);
		stop_cmd <= 1'b0;
		repeat (3) @(posedge clock);
		btn[1] <= 1'b0;
		wait_f(16'h0000);
		repeat (6) @(posedge clock);
		rdchk(`REG_SAVED_FREQ, 16'h0200);
		// 3-wire press latches the run after both are released
		wr(`REG_IN_FUNC0, 16'h0011);
		run_cmd <= 1'b0;
		stop_cmd <= 1'b0;
		push(2, 6);
		run_cmd <= 1'b1;
		repeat (2) @(posedge clock);
		run_cmd <= 1'b0;
		repeat (30) @(posedge clock);
		chk({15'h0000, running}, 16'h0001);
		// status: latch set, dwell done after the rearming stop, running
		rdchk(`REG_STATUS, 16'h0015);
		// other source: up input has no effect, no dwell when time is zero
		wr(`REG_DWELL_TIME, 16'h0000);
		wr(`REG_FREQ_SRC, 16'h0000);
		base_freq <= 16'h0150;
		stop_cmd <= 1'b1;
		repeat (4) @(posedge clock);
		stop_cmd <= 1'b0;
		run_cmd <= 1'b1;
		n = 0;
		repeat (20) begin
			@(posedge clock);
			#1 n += (dwelling !== 1'b0);
		end
		chk(16'(n), 16'h0000);
		wait_f(16'h0150);
		// jog overrides the ramp while running, then the ramp resumes
		@(posedge clock);
		jog_freq <= 16'h0180;
		jog_active <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk(cmd_freq, 16'h0180);
		@(posedge clock);
		jog_active <= 1'b0;
		wait_f(16'h0150);
		push(0, 100);
		chk(cmd_freq, 16'h0150);
		end_of_test();
	end
endmodule : tb_updown_freq_command_dwell
